// [design/sbra_regmap.sv]
`timescale 1ns/100ps
module sbra_regmap import sbra_pkg::*; #(
	parameter logic [7:0] FAMILY_ID = 8'h5A
) (
	// Clock, reset, enable
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic ce_in,
	// Serial port pins
	input wire logic spi_clk_in,
	input wire logic spi_csn_in,
	input wire logic spi_sdi_in,
	output logic spi_sdo_out,
	output logic spi_sdo_oe_out,
	// Chip state
	input wire logic [1:0] mode_actual_in,
	input wire logic mode_change_in,
	input wire logic restart_in,
	input wire logic cmd_block_in,
	input wire logic failure_trigger_in,
	input wire logic wake_pin_in,
	// Status events
	input wire logic [7:0] supply_status_set_in,
	input wire logic [7:0] thermal_status_set_in,
	input wire logic [7:0] device_status_set_in,
	input wire logic [7:0] bus_failure_first_set_in,
	input wire logic [7:0] bus_failure_second_set_in,
	input wire logic [7:0] wake_source_first_set_in,
	input wire logic [7:0] wake_source_second_set_in,
	input wire logic [7:0] switcher_status_set_in,
	// Control registers
	output logic [7:0] mode_supply_control_out,
	output logic [7:0] hardware_control_out,
	output logic [7:0] watchdog_control_out,
	output logic [7:0] bus_control_first_out,
	output logic [7:0] bus_control_second_out,
	output logic [7:0] wake_control_first_out,
	output logic [7:0] wake_control_second_out,
	output logic [7:0] wake_pin_pull_control_out,
	output logic [7:0] cyclic_timer_control_out,
	output logic [7:0] system_scratch_status_out,
	// Device effects
	output logic failure_outputs_out,
	output logic soft_reset_out
);
	// Synchronisers
	logic [2:0] sclk_q;
	logic [2:0] next_sclk_q;
	logic [2:0] csn_q;
	logic [2:0] next_csn_q;
	logic [1:0] sdi_q;
	logic [1:0] next_sdi_q;
	logic [1:0] wake_q;
	logic [1:0] next_wake_q;
	always_comb begin
		next_sclk_q = {sclk_q[1:0], spi_clk_in};
		next_csn_q = {csn_q[1:0], spi_csn_in};
		next_sdi_q = {sdi_q[0], spi_sdi_in};
		next_wake_q = {wake_q[0], wake_pin_in};
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			sclk_q <= 3'h0;
			csn_q <= 3'h7;
			sdi_q <= 2'h0;
			wake_q <= 2'h0;
		end else if (ce_in) begin
			sclk_q <= next_sclk_q;
			csn_q <= next_csn_q;
			sdi_q <= next_sdi_q;
			wake_q <= next_wake_q;
		end
	end
	logic sclk_rise;
	logic sclk_fall;
	logic csn_fall;
	logic csn_rise;
	assign sclk_rise = sclk_q[1] & ~sclk_q[2];
	assign sclk_fall = ~sclk_q[1] & sclk_q[2];
	assign csn_fall = ~csn_q[1] & csn_q[2];
	assign csn_rise = csn_q[1] & ~csn_q[2];

	// Address decoders and transceiver sleep encoding
	function automatic logic [3:0] ctrl_idx(input logic [6:0] a);
		ctrl_idx = IDX_NONE;
		for (int i = 0; i < N_CTRL; i++) begin
			if (CTRL_ADDR[i] == a) begin
				ctrl_idx = 4'(i);
			end
		end
	endfunction

	function automatic logic [3:0] stat_idx(input logic [6:0] a);
		stat_idx = IDX_NONE;
		for (int i = 0; i < N_STAT; i++) begin
			if (STAT_ADDR[i] == a) begin
				stat_idx = 4'(i);
			end
		end
	endfunction

	function automatic logic [1:0] xcvr_sleep(input logic [1:0] f);
		xcvr_sleep = (f == XCVR_ON) ? XCVR_WAKE : f;
	endfunction

	// Register storage
	logic [7:0] ctrl [N_CTRL];
	logic [7:0] stat [N_STAT];
	logic [7:0] next_ctrl [N_CTRL];
	logic [7:0] next_stat [N_STAT];
	logic fo;
	logic next_fo;
	logic soft_rst;
	logic next_soft_rst;
	logic [7:0] events [N_STAT];
	logic [7:0] summary;
	assign events[0] = supply_status_set_in;
	assign events[1] = thermal_status_set_in;
	assign events[2] = device_status_set_in;
	assign events[3] = bus_failure_first_set_in;
	assign events[4] = bus_failure_second_set_in;
	assign events[5] = wake_source_first_set_in;
	assign events[6] = wake_source_second_set_in;
	assign events[7] = switcher_status_set_in;
	genvar g;
	generate
		for (g = 0; g < N_STAT; g++) begin : g_sum
			assign summary[g] = |stat[g];
		end
	endgenerate

	// Frame state
	sbra_state_t state;
	sbra_state_t next_state;
	logic [4:0] cnt;
	logic [4:0] next_cnt;
	logic [15:0] rx;
	logic [15:0] next_rx;
	logic [15:0] tx;
	logic [15:0] next_tx;
	logic sdo;
	logic next_sdo;
	logic sdo_oe;
	logic next_sdo_oe;
	logic err;
	logic next_err;
	logic bad;
	logic next_bad;
	logic exec;
	logic [7:0] rd_byte;
	logic [3:0] rd_ci;
	logic [3:0] rd_si;

	// Read data for the address just received
	always_comb begin
		rd_ci = ctrl_idx(rx[ADDR_BITS-1:0]);
		rd_si = stat_idx(rx[ADDR_BITS-1:0]);
		rd_byte = 8'h00;
		if (rd_ci != IDX_NONE) begin
			rd_byte = ctrl[rd_ci];
		end else if (rd_si != IDX_NONE) begin
			rd_byte = stat[rd_si[2:0]];
		end else if (rx[ADDR_BITS-1:0] == ADDR_WAKE_LEVEL) begin
			rd_byte = {7'h00, wake_q[1]};
		end else if (rx[ADDR_BITS-1:0] == ADDR_FAMILY_ID) begin
			rd_byte = FAMILY_ID;
		end
	end

	always_comb begin
		next_state = state;
		next_cnt = cnt;
		next_rx = rx;
		next_tx = tx;
		next_sdo = sdo;
		next_sdo_oe = sdo_oe;
		next_err = err;
		next_bad = bad;
		exec = 1'b0;
		case (state)
			SBRA_IDLE: begin
				if (csn_fall) begin
					next_state = SBRA_FRAME;
					next_cnt = 5'h00;
					next_rx = 16'h0000;
					next_tx = {8'h00, summary};
					next_sdo = err;
					next_sdo_oe = 1'b1;
					next_bad = sclk_q[1];
				end
			end
			SBRA_FRAME: begin
				if (csn_rise) begin
					next_state = SBRA_IDLE;
					next_sdo_oe = 1'b0;
					next_sdo = 1'b0;
					next_err = (cnt != 5'h00 && cnt != CNT_FRAME) | bad | sclk_q[1];
					exec = (cnt == CNT_FRAME) & ~bad & ~sclk_q[1] & ~cmd_block_in;
				end else begin
					if (sclk_fall) begin
						if (cnt < CNT_FRAME) begin
							next_rx[cnt[3:0]] = sdi_q[1];
						end
						if (cnt + 5'h01 == CNT_ADDR_DONE) begin
							next_tx[15:DATA_LSB] = rd_byte;
						end
						if (cnt != CNT_MAX) begin
							next_cnt = cnt + 5'h01;
						end
					end
					if (sclk_rise && cnt < CNT_FRAME) begin
						next_sdo = tx[cnt[3:0]];
					end
				end
			end
			default: begin
				next_state = SBRA_IDLE;
				next_sdo_oe = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			state <= SBRA_IDLE;
			cnt <= 5'h00;
			rx <= 16'h0000;
			tx <= 16'h0000;
			sdo <= 1'b0;
			sdo_oe <= 1'b0;
			err <= 1'b0;
			bad <= 1'b0;
		end else if (ce_in) begin
			state <= next_state;
			cnt <= next_cnt;
			rx <= next_rx;
			tx <= next_tx;
			sdo <= next_sdo;
			sdo_oe <= next_sdo_oe;
			err <= next_err;
			bad <= next_bad;
		end
	end

	// Register update
	logic [3:0] wr_ci;
	logic [3:0] wr_si;
	logic wr_acc;
	logic [7:0] wdata;
	logic [7:0] wval;
	always_comb begin
		wr_ci = ctrl_idx(rx[ADDR_BITS-1:0]);
		wr_si = stat_idx(rx[ADDR_BITS-1:0]);
		wr_acc = rx[ACC_BIT];
		wdata = rx[15:DATA_LSB];
		wval = 8'h00;
		next_soft_rst = 1'b0;
		for (int i = 0; i < N_CTRL; i++) begin
			next_ctrl[i] = ctrl[i];
		end
		for (int i = 0; i < N_STAT; i++) begin
			next_stat[i] = stat[i];
		end
		if (exec && wr_acc && wr_si != IDX_NONE) begin
			next_stat[wr_si[2:0]] = 8'h00;
		end
		for (int i = 0; i < N_STAT; i++) begin
			next_stat[i] = next_stat[i] | (events[i] & STAT_MASK[i]);
		end
		if (exec && wr_acc && wr_ci != IDX_NONE) begin
			wval = (ctrl[wr_ci] & ~CTRL_WMASK[wr_ci])
				| (wdata & CTRL_WMASK[wr_ci]);
			if (wr_ci == 4'(I_MODE) && mode_actual_in != MODE_NORMAL) begin
				wval[SUPPLY2_LSB +: 2] = ctrl[I_MODE][SUPPLY2_LSB +: 2];
			end
			next_ctrl[wr_ci] = wval;
			if (wr_ci == 4'(I_MODE) && wdata[MODE_LSB +: 2] == MODE_SOFT_RST) begin
				next_soft_rst = 1'b1;
			end
		end
		if (mode_change_in) begin
			next_ctrl[I_MODE][MODE_LSB +: 2] = mode_actual_in;
			if (mode_actual_in == MODE_SLEEP) begin
				next_ctrl[I_BUS1][CAN_LSB +: 2] =
					xcvr_sleep(ctrl[I_BUS1][CAN_LSB +: 2]);
				next_ctrl[I_BUS1][LIN1_LSB +: 2] = xcvr_sleep(ctrl[I_BUS1][LIN1_LSB +: 2]);
				next_ctrl[I_BUS2][LIN2_LSB +: 2] =
					xcvr_sleep(ctrl[I_BUS2][LIN2_LSB +: 2]);
				next_ctrl[I_BUS2][LIN3_LSB +: 2] = xcvr_sleep(ctrl[I_BUS2][LIN3_LSB +: 2]);
			end
		end
		next_fo = fo | failure_trigger_in | ctrl[I_HW][FO_ON_BIT];
		if (restart_in) begin
			for (int i = 0; i < N_CTRL; i++) begin
				next_ctrl[i] = (ctrl[i] & CTRL_KEEP[i])
					| (CTRL_RST_VAL[i] & ~CTRL_KEEP[i]);
			end
		end
		if (next_soft_rst) begin
			for (int i = 0; i < N_CTRL; i++) begin
				next_ctrl[i] = CTRL_POR[i];
			end
			for (int i = 0; i < N_STAT; i++) begin
				next_stat[i] = 8'h00;
			end
			next_fo = 1'b0;
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			for (int i = 0; i < N_CTRL; i++) begin
				ctrl[i] <= CTRL_POR[i];
			end
			for (int i = 0; i < N_STAT; i++) begin
				stat[i] <= 8'h00;
			end
			fo <= 1'b0;
			soft_rst <= 1'b0;
		end else if (ce_in) begin
			for (int i = 0; i < N_CTRL; i++) begin
				ctrl[i] <= next_ctrl[i];
			end
			for (int i = 0; i < N_STAT; i++) begin
				stat[i] <= next_stat[i];
			end
			fo <= next_fo;
			soft_rst <= next_soft_rst;
		end
	end

	// Outputs
	assign spi_sdo_out = sdo;
	assign spi_sdo_oe_out = sdo_oe;
	assign mode_supply_control_out = ctrl[0];
	assign hardware_control_out = ctrl[1];
	assign watchdog_control_out = ctrl[2];
	assign bus_control_first_out = ctrl[3];
	assign bus_control_second_out = ctrl[4];
	assign wake_control_first_out = ctrl[5];
	assign wake_control_second_out = ctrl[6];
	assign wake_pin_pull_control_out = ctrl[7];
	assign cyclic_timer_control_out = ctrl[8];
	assign system_scratch_status_out = ctrl[9];
	assign failure_outputs_out = fo;
	assign soft_reset_out = soft_rst;
endmodule

// [inc/sbra_pkg.sv]
package sbra_pkg;
	// Register counts and command layout
	localparam int N_CTRL = 10;
	localparam int N_STAT = 8;
	localparam int FRAME_BITS = 16;
	localparam int ADDR_BITS = 7;
	localparam int ACC_BIT = 7;
	localparam int DATA_LSB = 8;
	localparam logic [4:0] CNT_ADDR_DONE = 5'h08;
	localparam logic [4:0] CNT_FRAME = 5'h10;
	localparam logic [4:0] CNT_MAX = 5'h1F;
	localparam logic [3:0] IDX_NONE = 4'hF;
	// Control register addresses, index 9 first
	localparam logic [9:0][6:0] CTRL_ADDR = {7'h1E, 7'h0C, 7'h08, 7'h07, 7'h06,
		7'h05, 7'h04, 7'h03, 7'h02, 7'h01};
	localparam logic [9:0][7:0] CTRL_POR = {8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h00, 8'h14, 8'h00, 8'h00};
	localparam logic [9:0][7:0] CTRL_RST_VAL = {8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h00, 8'h04, 8'h00, 8'h00};
	localparam logic [9:0][7:0] CTRL_KEEP = {8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF,
		8'hFF, 8'hFF, 8'h98, 8'hDF, 8'h07};
	localparam logic [9:0][7:0] CTRL_WMASK = {8'hFF, 8'h07, 8'h03, 8'h01, 8'h44,
		8'h1B, 8'hFB, 8'hFF, 8'hFF, 8'hDF};
	// Status register addresses, index 7 first
	localparam logic [7:0][6:0] STAT_ADDR = {7'h4C, 7'h47, 7'h46, 7'h45, 7'h44,
		7'h43, 7'h42, 7'h41};
	localparam logic [7:0][7:0] STAT_MASK = {8'hF7, 8'h07, 8'hB1, 8'h1E, 8'h67,
		8'hFF, 8'h07, 8'hFD};
	localparam logic [6:0] ADDR_WAKE_LEVEL = 7'h48;
	localparam logic [6:0] ADDR_FAMILY_ID = 7'h7E;
	// Register indices and field positions
	localparam int I_MODE = 0;
	localparam int I_HW = 1;
	localparam int I_BUS1 = 3;
	localparam int I_BUS2 = 4;
	localparam int MODE_LSB = 6;
	localparam int SUPPLY2_LSB = 3;
	localparam int FO_ON_BIT = 5;
	localparam int CAN_LSB = 0;
	localparam int LIN1_LSB = 3;
	localparam int LIN2_LSB = 0;
	localparam int LIN3_LSB = 3;
	// Mode and transceiver encodings
	localparam logic [1:0] MODE_NORMAL = 2'h0;
	localparam logic [1:0] MODE_SLEEP = 2'h1;
	localparam logic [1:0] MODE_STOP = 2'h2;
	localparam logic [1:0] MODE_SOFT_RST = 2'h3;
	localparam logic [1:0] XCVR_WAKE = 2'h1;
	localparam logic [1:0] XCVR_ON = 2'h3;
	typedef enum logic [1:0] {
		SBRA_IDLE = 2'b01,
		SBRA_FRAME = 2'b10
	} sbra_state_t;
endpackage

// [sim/sbra_regmap_asserts.sv]
`timescale 1ns/100ps
module sbra_regmap_asserts import sbra_pkg::*; (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_in,
	// Watched signals
	input wire logic spi_csn_in,
	input wire logic spi_sdo_oe_out,
	input wire logic soft_reset_out,
	input wire logic [1:0] mode_actual_in,
	input wire logic mode_change_in,
	input wire logic restart_in,
	input wire logic cmd_block_in,
	input wire logic failure_trigger_in,
	input wire logic failure_outputs_out,
	input wire logic [7:0] mode_supply_control_out,
	input wire logic [7:0] bus_control_first_out,
	input wire logic [7:0] watchdog_control_out,
	input wire logic [7:0] system_scratch_status_out
);
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (rst_in);
	AST_OE_ON: assert property (!spi_csn_in [*5] |-> spi_sdo_oe_out)
		else $error("sdo not driven in frame");
	AST_SOFT_POR: assert property (soft_reset_out |-> ##[0:2]
		(watchdog_control_out == CTRL_POR[2] && mode_supply_control_out == CTRL_POR[0]))
		else $error("soft reset left registers");
	AST_MODE_FOLLOW: assert property (mode_change_in |=>
		mode_supply_control_out[MODE_LSB+:2] == $past(mode_actual_in))
		else $error("mode field not updated");
	AST_SLEEP_WAKE: assert property (mode_change_in && mode_actual_in == MODE_SLEEP &&
		bus_control_first_out[CAN_LSB+:2] == XCVR_ON
		|=> bus_control_first_out[CAN_LSB+:2] == XCVR_WAKE)
		else $error("transceiver not wake capable");
	AST_FAIL_KEEP: assert property (failure_outputs_out && mode_change_in |=> failure_outputs_out)
		else $error("failure output dropped");
	AST_FAIL_SET: assert property ($rose(failure_trigger_in) |-> ##[1:2] failure_outputs_out)
		else $error("failure output not set");
	AST_BLOCK: assert property (cmd_block_in |=> $stable(system_scratch_status_out))
		else $error("register changed while blocked");
	AST_RESTART: assert property (restart_in |=>
		(watchdog_control_out & ~CTRL_KEEP[2]) == CTRL_RST_VAL[2])
		else $error("restart value wrong");
endmodule
bind sbra_regmap sbra_regmap_asserts u_asserts (
	.clk_in(clk_in),
	.rst_in(rst_in),
	.spi_csn_in(spi_csn_in),
	.spi_sdo_oe_out(spi_sdo_oe_out),
	.soft_reset_out(soft_reset_out),
	.mode_actual_in(mode_actual_in),
	.mode_change_in(mode_change_in),
	.restart_in(restart_in),
	.cmd_block_in(cmd_block_in),
	.failure_trigger_in(failure_trigger_in),
	.failure_outputs_out(failure_outputs_out),
	.mode_supply_control_out(mode_supply_control_out),
	.bus_control_first_out(bus_control_first_out),
	.watchdog_control_out(watchdog_control_out),
	.system_scratch_status_out(system_scratch_status_out)
);

// [sim/sbra_regmap_tb.sv]
`timescale 1ns/100ps
module sbra_regmap_tb import sbra_pkg::*;;
	localparam logic [7:0] FAM = 8'hA3; // Arbitrary value
	logic clk_in, spi_clk_in, spi_csn_in, spi_sdi_in, spi_sdo_out, spi_sdo_oe_out;
	logic rst_in = 1'b1, ce_in = 1'b1, mode_change_in = 1'b0, restart_in = 1'b0;
	logic cmd_block_in = 1'b0, failure_trigger_in = 1'b0, wake_pin_in = 1'b0;
	logic [1:0] mode_actual_in = MODE_NORMAL;
	logic [7:0][7:0] st_set = '0;
	logic [7:0] mode_supply_control_out, hardware_control_out, watchdog_control_out;
	logic [7:0] bus_control_first_out, bus_control_second_out, wake_control_first_out;
	logic [7:0] wake_control_second_out, wake_pin_pull_control_out, cyclic_timer_control_out;
	logic [7:0] system_scratch_status_out, d;
	logic [7:0] ec [N_CTRL];
	logic failure_outputs_out, soft_reset_out, err;
	logic [15:0] rsp;
	logic [9:0][7:0] outs;
	logic sdo_line;
	int n_soft = 0;
	logic [31:0] seed = 32'h0001077A;
	int n_errors = 0;
	int checks = 0;
	int cyc = 0;
	sbra_regmap #(.FAMILY_ID(FAM)) DUT (.*,
		.supply_status_set_in(st_set[0]), .thermal_status_set_in(st_set[1]),
		.device_status_set_in(st_set[2]), .bus_failure_first_set_in(st_set[3]),
		.bus_failure_second_set_in(st_set[4]), .wake_source_first_set_in(st_set[5]),
		.wake_source_second_set_in(st_set[6]), .switcher_status_set_in(st_set[7]));
	assign outs = {system_scratch_status_out, cyclic_timer_control_out,
		wake_pin_pull_control_out, wake_control_second_out, wake_control_first_out,
		bus_control_second_out, bus_control_first_out, watchdog_control_out,
		hardware_control_out, mode_supply_control_out};
	// Released line shows the opposite level
	assign sdo_line = spi_sdo_oe_out ? spi_sdo_out : ~spi_sdo_out;
	sbra_spi_host u_host (.clk_in(clk_in), .spi_sdo_in(sdo_line),
		.spi_clk_out(spi_clk_in), .spi_csn_out(spi_csn_in), .spi_sdi_out(spi_sdi_in));
	initial begin
		clk_in = 1'b0;
		forever #10 clk_in = ~clk_in;
	end
	function automatic logic [7:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[7:0];
	endfunction
	function automatic logic [7:0] wexp(input int i, input logic [7:0] o, input logic [7:0] v);
		return (o & ~CTRL_WMASK[i]) | (v & CTRL_WMASK[i]);
	endfunction
	task automatic give_verdict();
		if (n_errors == 0 && checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		checks++;
		if (g !== e) begin
			n_errors++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic cmd(input logic [6:0] a, input logic w, input logic [7:0] v);
		u_host.xfer({v, w, a}, 16, rsp, err);
	endtask
	always @(posedge clk_in) begin
		cyc <= cyc + 1;
		if (soft_reset_out === 1'b1) begin
			n_soft <= n_soft + 1;
		end
		if (cyc == 40000) begin
			n_errors++;
			give_verdict();
		end
	end
	initial begin
		repeat (20) @(posedge clk_in);
		rst_in <= 1'b0;
		@(posedge clk_in);
		for (int i = 0; i < N_CTRL; i++) begin
			d = rnd();
			if (i == I_MODE) d[7:6] = MODE_NORMAL;
			cmd(CTRL_ADDR[i], 1'b0, ~d);
			chk(rsp[15:8], CTRL_POR[i]);
			cmd(CTRL_ADDR[i], 1'b1, d);
			chk(rsp[15:8], CTRL_POR[i]);
			ec[i] = wexp(i, CTRL_POR[i], d);
			chk(outs[i], ec[i]);
			cmd(CTRL_ADDR[i], 1'b0, ~d);
			chk(rsp[15:8], ec[i]);
			cmd(CTRL_ADDR[i], 1'b0, d);
			chk(rsp[15:8], ec[i]);
		end
		chk(system_scratch_status_out, ec[9]);
		chk({7'h00, spi_sdo_oe_out}, 8'h00);
		cmd(7'h10, 1'b1, 8'hFF);
		chk(rsp[15:8], 8'h00);
		for (int i = 0; i < N_CTRL; i++) begin
			chk(outs[i], ec[i]);
		end
		for (int i = 0; i < N_STAT; i++) begin
			d = rnd() & STAT_MASK[i];
			if (d == 8'h00) d = STAT_MASK[i];
			st_set[i] <= d;
			@(posedge clk_in);
			st_set[i] <= 8'h00;
			cmd(STAT_ADDR[i], 1'b0, 8'hFF);
			chk(rsp[15:8], d);
			chk(rsp[7:0], 8'h01 << i);
			cmd(STAT_ADDR[i], 1'b1, 8'h00);
			chk(rsp[15:8], d);
			cmd(STAT_ADDR[i], 1'b0, 8'h00);
			chk(rsp[15:8], 8'h00);
			chk(rsp[7:0], 8'h00);
		end
		wake_pin_in <= 1'b1;
		cmd(ADDR_WAKE_LEVEL, 1'b1, 8'hFF);
		cmd(ADDR_WAKE_LEVEL, 1'b0, 8'h00);
		chk(rsp[15:8], 8'h01);
		cmd(ADDR_FAMILY_ID, 1'b1, 8'h00);
		chk(rsp[15:8], FAM);
		cmd(ADDR_FAMILY_ID, 1'b0, 8'h00);
		chk(rsp[15:8], FAM);
		u_host.xfer({~ec[9], 1'b1, CTRL_ADDR[9]}, 15, rsp, err);
		cmd(CTRL_ADDR[9], 1'b0, 8'h00);
		chk({7'h00, err}, 8'h01);
		chk(rsp[15:8], ec[9]);
		cmd_block_in <= 1'b1;
		cmd(CTRL_ADDR[9], 1'b1, ~ec[9]);
		cmd_block_in <= 1'b0;
		cmd(CTRL_ADDR[9], 1'b0, 8'h00);
		chk({7'h00, err}, 8'h00);
		chk(rsp[15:8], ec[9]);
		cmd(CTRL_ADDR[I_BUS1], 1'b1, 8'h1B);
		failure_trigger_in <= 1'b1;
		@(posedge clk_in);
		failure_trigger_in <= 1'b0;
		mode_change_in <= 1'b1;
		mode_actual_in <= MODE_SLEEP;
		@(posedge clk_in);
		mode_change_in <= 1'b0;
		@(posedge clk_in);
		chk(bus_control_first_out, 8'h09);
		chk(mode_supply_control_out, {MODE_SLEEP, ec[0][5:0]});
		chk({7'h00, failure_outputs_out}, 8'h01);
		cmd(CTRL_ADDR[I_MODE], 1'b1, 8'h18);
		cmd(CTRL_ADDR[I_MODE], 1'b0, 8'h00);
		chk(rsp[15:8], ec[0] & 8'h18);
		mode_change_in <= 1'b1;
		mode_actual_in <= MODE_NORMAL;
		@(posedge clk_in);
		mode_change_in <= 1'b0;
		restart_in <= 1'b1;
		@(posedge clk_in);
		restart_in <= 1'b0;
		for (int i = 1; i < 3; i++) begin
			cmd(CTRL_ADDR[i], 1'b0, 8'h00);
			chk(rsp[15:8], (ec[i] & CTRL_KEEP[i]) | CTRL_RST_VAL[i]);
		end
		cmd(CTRL_ADDR[I_BUS1], 1'b0, 8'h00);
		chk(rsp[15:8], 8'h09);
		cmd(CTRL_ADDR[I_MODE], 1'b1, {MODE_SOFT_RST, 6'h00});
		chk(8'(n_soft), 8'h01);
		for (int i = 0; i < N_CTRL; i++) begin
			cmd(CTRL_ADDR[i], 1'b0, 8'h00);
			chk(rsp[15:8], CTRL_POR[i]);
			chk(outs[i], CTRL_POR[i]);
		end
		chk({7'h00, failure_outputs_out}, 8'h00);
		give_verdict();
	end
endmodule

// [sim/sbra_spi_host.sv]
`timescale 1ns/100ps
module sbra_spi_host (
	// Clock
	input wire logic clk_in,
	// Serial pins
	input wire logic spi_sdo_in,
	output logic spi_clk_out,
	output logic spi_csn_out,
	output logic spi_sdi_out
);
	initial begin
		spi_clk_out = 1'b0;
		spi_csn_out = 1'b1;
		spi_sdi_out = 1'b0;
	end
	task automatic hw();
		repeat (4) @(posedge clk_in);
	endtask
	task automatic xfer(input logic [15:0] c, input int n, output logic [15:0] r,
		output logic e);
		r = 16'h0000;
		spi_csn_out <= 1'b0;
		hw();
		hw();
		e = spi_sdo_in;
		for (int i = 0; i < n; i++) begin
			spi_sdi_out <= c[i];
			spi_clk_out <= 1'b1;
			hw();
			r[i] = spi_sdo_in;
			spi_clk_out <= 1'b0;
			hw();
		end
		spi_csn_out <= 1'b1;
		spi_sdi_out <= ~spi_sdi_out;
		hw();
		hw();
	endtask
endmodule
